// >>> design/aer_error_logging_regs.sv
`timescale 1ns/1ps
`default_nettype none

module aer_error_logging_regs #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic reset_n_in,
   // register port
   input wire aer_pkg::reg_req_t req_in,
   output logic [31:0] rdata_out,
   // error events, same clock
   input wire logic [31:0] corr_event_in,
   input wire logic [31:0] sec_event_in,
   input wire logic internal_error_in,
   input wire aer_pkg::primary_error_t primary_error_in,
   input wire logic primary_log_release_in,
   // secondary bus pins, asynchronous
   input wire logic parity_error_pin_low_in,
   input wire logic system_error_pin_low_in,
   // control outputs
   output logic ecrc_gen_enable_out,
   output logic ecrc_check_enable_out,
   output logic primary_log_held_out,
   output logic irq_out
);

   generate
      if (ADDR_W != 12)
      begin : g_addr_check
         $error("aer_error_logging_regs: ADDR_W must be 12");
      end
   endgenerate

   logic [31:0] corr_flags;
   logic [31:0] corr_masks;
   logic [4:0] first_ptr;
   logic ecrc_gen_en;
   logic ecrc_chk_en;
   logic [127:0] hdr_log;
   logic primary_held;
   logic [31:0] sec_flags;
   logic [31:0] sec_masks;
   logic [31:0] sec_sev;
   logic [4:0] sec_first_ptr;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic [31:0] rdata;

   logic [2:0] parity_sync;
   logic [2:0] system_sync;

   logic wr_corr_flags;
   logic wr_corr_masks;
   logic wr_adv_ctrl;
   logic wr_sec_flags;
   logic wr_sec_masks;
   logic wr_sec_sev;
   logic wr_irq_mask;
   logic rd_irq_status;

   logic [31:0] corr_set;
   logic [31:0] sec_set;
   logic [31:0] sec_new_unmasked;
   logic sec_ptr_free;
   logic [2:0] irq_set;
   logic [31:0] adv_ctrl_word;
   logic [31:0] next_rdata;

   function automatic logic [4:0] lowest_index(input logic [31:0] vec);
      logic [4:0] idx;
      idx = 5'h00;
      for (int i = 31; i >= 0; i--)
      begin
         if (vec[i])
         begin
            idx = 5'(i);
         end
      end
      return idx;
   endfunction

   // pin synchronisers, stage 0 read only by stage 1
   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         parity_sync <= 3'h7;
         system_sync <= 3'h7;
      end
      else
      begin
         parity_sync <= {parity_sync[1:0], parity_error_pin_low_in};
         system_sync <= {system_sync[1:0], system_error_pin_low_in};
      end
   end

   // write decode
   always_comb
   begin
      wr_corr_flags = 1'b0;
      wr_corr_masks = 1'b0;
      wr_adv_ctrl = 1'b0;
      wr_sec_flags = 1'b0;
      wr_sec_masks = 1'b0;
      wr_sec_sev = 1'b0;
      wr_irq_mask = 1'b0;
      if (!req_in.wr)
      begin
         wr_corr_flags = 1'b0;
      end
      else if (req_in.addr == aer_pkg::CORR_FLAGS_OFS)
      begin
         wr_corr_flags = 1'b1;
      end
      else if (req_in.addr == aer_pkg::CORR_MASKS_OFS)
      begin
         wr_corr_masks = 1'b1;
      end
      else if (req_in.addr == aer_pkg::ADV_CTRL_OFS)
      begin
         wr_adv_ctrl = 1'b1;
      end
      else if (req_in.addr == aer_pkg::SEC_FLAGS_OFS)
      begin
         wr_sec_flags = 1'b1;
      end
      else if (req_in.addr == aer_pkg::SEC_MASKS_OFS)
      begin
         wr_sec_masks = 1'b1;
      end
      else if (req_in.addr == aer_pkg::SEC_SEV_OFS)
      begin
         wr_sec_sev = 1'b1;
      end
      else if (req_in.addr == aer_pkg::IRQ_MASK_OFS)
      begin
         wr_irq_mask = 1'b1;
      end
   end

   assign rd_irq_status = req_in.rd && (req_in.addr == aer_pkg::IRQ_STATUS_OFS);

   // event collection
   always_comb
   begin
      corr_set = corr_event_in & aer_pkg::CORR_IMPL;
      sec_set = sec_event_in;
      sec_set[aer_pkg::SEC_PARITY_PIN_BIT] = parity_sync[2] & ~parity_sync[1];
      sec_set[aer_pkg::SEC_SYSTEM_PIN_BIT] = system_sync[2] & ~system_sync[1];
      sec_set[aer_pkg::SEC_INTERNAL_BIT] = internal_error_in;
      sec_set = sec_set & aer_pkg::SEC_IMPL;
      sec_new_unmasked = sec_set & ~sec_masks;
      sec_ptr_free = ((sec_flags & ~sec_masks) == 32'h0000_0000);
   end

   // correctable flags, set wins over clear
   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         corr_flags <= aer_pkg::CORR_FLAGS_RST;
      end
      else
      begin
         corr_flags <= ((corr_flags & ~(wr_corr_flags ? req_in.wdata : 32'h0000_0000))
            | corr_set) & aer_pkg::CORR_IMPL;
      end
   end

   // correctable masks
   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         corr_masks <= aer_pkg::CORR_MASKS_RST;
      end
      else if (wr_corr_masks)
      begin
         corr_masks <= req_in.wdata & aer_pkg::CORR_IMPL;
      end
   end

   // ecrc enables
   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         ecrc_gen_en <= 1'b0;
         ecrc_chk_en <= 1'b0;
      end
      else if (wr_adv_ctrl)
      begin
         ecrc_gen_en <= req_in.wdata[aer_pkg::ECRC_GEN_EN_BIT];
         ecrc_chk_en <= req_in.wdata[aer_pkg::ECRC_CHK_EN_BIT];
      end
   end

   // primary first error pointer and header capture
   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         first_ptr <= aer_pkg::FIRST_PTR_RST;
         hdr_log <= aer_pkg::HDR_LOG_RST;
         primary_held <= 1'b0;
      end
      else if (primary_error_in.valid && !primary_held)
      begin
         first_ptr <= primary_error_in.index;
         hdr_log <= primary_error_in.header;
         primary_held <= 1'b1;
      end
      else if (primary_log_release_in)
      begin
         primary_held <= 1'b0;
      end
   end

   // secondary flags, set wins over clear
   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         sec_flags <= aer_pkg::SEC_FLAGS_RST;
      end
      else
      begin
         sec_flags <= ((sec_flags & ~(wr_sec_flags ? req_in.wdata : 32'h0000_0000))
            | sec_set) & aer_pkg::SEC_IMPL;
      end
   end

   // secondary masks and severity
   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         sec_masks <= aer_pkg::SEC_MASKS_RST;
      end
      else if (wr_sec_masks)
      begin
         sec_masks <= req_in.wdata & aer_pkg::SEC_IMPL;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         sec_sev <= aer_pkg::SEC_SEV_RST;
      end
      else if (wr_sec_sev)
      begin
         sec_sev <= req_in.wdata & aer_pkg::SEC_IMPL;
      end
   end

   // secondary first error pointer
   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         sec_first_ptr <= aer_pkg::FIRST_PTR_RST;
      end
      else if (sec_ptr_free && (sec_new_unmasked != 32'h0000_0000))
      begin
         sec_first_ptr <= lowest_index(sec_new_unmasked);
      end
   end

   // interrupt status, clear on read, set wins
   always_comb
   begin
      irq_set = 3'h0;
      irq_set[aer_pkg::IRQ_CORR_BIT] = |(corr_set & ~corr_masks);
      irq_set[aer_pkg::IRQ_SEC_NONFATAL_BIT] = |(sec_new_unmasked & ~sec_sev);
      irq_set[aer_pkg::IRQ_SEC_FATAL_BIT] = |(sec_new_unmasked & sec_sev);
   end

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         irq_status <= aer_pkg::IRQ_STATUS_RST;
      end
      else
      begin
         irq_status <= ((rd_irq_status ? 3'h0 : irq_status) | irq_set) & aer_pkg::IRQ_IMPL;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         irq_mask <= aer_pkg::IRQ_MASK_RST;
      end
      else if (wr_irq_mask)
      begin
         irq_mask <= req_in.wdata[2:0] & aer_pkg::IRQ_IMPL;
      end
   end

   // read mux
   always_comb
   begin
      adv_ctrl_word = 32'h0000_0000;
      adv_ctrl_word[aer_pkg::FIRST_PTR_LSB +: aer_pkg::FIRST_PTR_W] = first_ptr;
      adv_ctrl_word[aer_pkg::ECRC_GEN_CAP_BIT] = 1'b1;
      adv_ctrl_word[aer_pkg::ECRC_GEN_EN_BIT] = ecrc_gen_en;
      adv_ctrl_word[aer_pkg::ECRC_CHK_CAP_BIT] = 1'b1;
      adv_ctrl_word[aer_pkg::ECRC_CHK_EN_BIT] = ecrc_chk_en;
      next_rdata = 32'h0000_0000;
      if (!req_in.rd)
      begin
         next_rdata = 32'h0000_0000;
      end
      else if (req_in.addr == aer_pkg::CORR_FLAGS_OFS)
      begin
         next_rdata = corr_flags;
      end
      else if (req_in.addr == aer_pkg::CORR_MASKS_OFS)
      begin
         next_rdata = corr_masks;
      end
      else if (req_in.addr == aer_pkg::ADV_CTRL_OFS)
      begin
         next_rdata = adv_ctrl_word;
      end
      else if (req_in.addr == aer_pkg::HDR_LOG0_OFS)
      begin
         next_rdata = hdr_log[127:96];
      end
      else if (req_in.addr == aer_pkg::HDR_LOG1_OFS)
      begin
         next_rdata = hdr_log[95:64];
      end
      else if (req_in.addr == aer_pkg::HDR_LOG2_OFS)
      begin
         next_rdata = hdr_log[63:32];
      end
      else if (req_in.addr == aer_pkg::HDR_LOG3_OFS)
      begin
         next_rdata = hdr_log[31:0];
      end
      else if (req_in.addr == aer_pkg::SEC_FLAGS_OFS)
      begin
         next_rdata = sec_flags;
      end
      else if (req_in.addr == aer_pkg::SEC_MASKS_OFS)
      begin
         next_rdata = sec_masks;
      end
      else if (req_in.addr == aer_pkg::SEC_SEV_OFS)
      begin
         next_rdata = sec_sev;
      end
      else if (req_in.addr == aer_pkg::SEC_CTRL_OFS)
      begin
         next_rdata = {27'h0, sec_first_ptr};
      end
      else if (req_in.addr == aer_pkg::IRQ_STATUS_OFS)
      begin
         next_rdata = {29'h0, irq_status};
      end
      else if (req_in.addr == aer_pkg::IRQ_MASK_OFS)
      begin
         next_rdata = {29'h0, irq_mask};
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!reset_n_in)
      begin
         rdata <= 32'h0000_0000;
      end
      else
      begin
         rdata <= next_rdata;
      end
   end

   assign rdata_out = rdata;
   assign ecrc_gen_enable_out = ecrc_gen_en;
   assign ecrc_check_enable_out = ecrc_chk_en;
   assign primary_log_held_out = primary_held;
   assign irq_out = |(irq_status & irq_mask);

endmodule // aer_error_logging_regs

`default_nettype wire

// >>> design/aer_pkg.sv
package aer_pkg;

   // register byte offsets
   localparam logic [11:0] CORR_FLAGS_OFS = 12'h110;
   localparam logic [11:0] CORR_MASKS_OFS = 12'h114;
   localparam logic [11:0] ADV_CTRL_OFS = 12'h118;
   localparam logic [11:0] HDR_LOG0_OFS = 12'h11c;
   localparam logic [11:0] HDR_LOG1_OFS = 12'h120;
   localparam logic [11:0] HDR_LOG2_OFS = 12'h124;
   localparam logic [11:0] HDR_LOG3_OFS = 12'h128;
   localparam logic [11:0] SEC_FLAGS_OFS = 12'h12c;
   localparam logic [11:0] SEC_MASKS_OFS = 12'h130;
   localparam logic [11:0] SEC_SEV_OFS = 12'h134;
   localparam logic [11:0] SEC_CTRL_OFS = 12'h138;
   localparam logic [11:0] IRQ_STATUS_OFS = 12'h170;
   localparam logic [11:0] IRQ_MASK_OFS = 12'h174;

   // implemented bits and reset values
   localparam logic [31:0] CORR_IMPL = 32'h0000_11c1;
   localparam logic [31:0] CORR_FLAGS_RST = 32'h0000_0000;
   localparam logic [31:0] CORR_MASKS_RST = 32'h0000_0000;
   localparam logic [31:0] SEC_IMPL = 32'h0000_3fef;
   localparam logic [31:0] SEC_FLAGS_RST = 32'h0000_0000;
   localparam logic [31:0] SEC_MASKS_RST = 32'h0000_17a8;
   localparam logic [31:0] SEC_SEV_RST = 32'h0000_1340;
   localparam logic [4:0] FIRST_PTR_RST = 5'h00;
   localparam logic [127:0] HDR_LOG_RST = 128'h0;
   localparam logic [2:0] IRQ_IMPL = 3'h7;
   localparam logic [2:0] IRQ_STATUS_RST = 3'h0;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;

   // advanced control field positions
   localparam int FIRST_PTR_LSB = 0;
   localparam int FIRST_PTR_W = 5;
   localparam int ECRC_GEN_CAP_BIT = 5;
   localparam int ECRC_GEN_EN_BIT = 6;
   localparam int ECRC_CHK_CAP_BIT = 7;
   localparam int ECRC_CHK_EN_BIT = 8;

   // secondary flag positions fed by pins and internal logic
   localparam int SEC_PARITY_PIN_BIT = 11;
   localparam int SEC_SYSTEM_PIN_BIT = 12;
   localparam int SEC_INTERNAL_BIT = 13;

   // interrupt status bits
   localparam int IRQ_CORR_BIT = 0;
   localparam int IRQ_SEC_NONFATAL_BIT = 1;
   localparam int IRQ_SEC_FATAL_BIT = 2;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic valid;
      logic [4:0] index;
      logic [127:0] header;
   } primary_error_t;

endpackage

// >>> test/aer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module aer_checker (
   // clock and reset
   input wire logic mclk_in,
   input wire logic reset_n_in,
   // watched ports
   input wire aer_pkg::reg_req_t req_in,
   input wire logic internal_error_in,
   input wire logic [31:0] rdata_out,
   input wire logic ecrc_gen_enable_out
);
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!reset_n_in);

   sequence s_rd(logic [11:0] a);
      req_in.rd && req_in.addr == a;
   endsequence
   sequence s_bridge;
      internal_error_in ##1 !req_in.wr ##1 s_rd(aer_pkg::SEC_FLAGS_OFS);
   endsequence

   property p_idle;
      !req_in.rd |=> rdata_out == 32'h0;
   endproperty
   property p_corr_rsv;
      s_rd(aer_pkg::CORR_FLAGS_OFS) |=> (rdata_out & ~aer_pkg::CORR_IMPL) == 32'h0;
   endproperty
   property p_mask_rsv;
      s_rd(aer_pkg::CORR_MASKS_OFS) |=> (rdata_out & ~aer_pkg::CORR_IMPL) == 32'h0;
   endproperty
   property p_caps;
      s_rd(aer_pkg::ADV_CTRL_OFS) |=> rdata_out[31:9] == 23'h0 && rdata_out[7] && rdata_out[5];
   endproperty
   property p_gen_en;
      req_in.wr && req_in.addr == aer_pkg::ADV_CTRL_OFS
         |=> ecrc_gen_enable_out == $past(req_in.wdata[6]);
   endproperty
   property p_sec_rsv;
      s_rd(aer_pkg::SEC_FLAGS_OFS) |=> (rdata_out & ~aer_pkg::SEC_IMPL) == 32'h0;
   endproperty
   property p_bridge;
      s_bridge |=> rdata_out[13];
   endproperty
   property p_ptr;
      s_rd(aer_pkg::SEC_CTRL_OFS) |=> rdata_out[31:5] == 27'h0;
   endproperty

   a_idle: assert property (p_idle) else $error("read data not zero when idle");
   a_corr_rsv: assert property (p_corr_rsv) else $error("correctable flag reserved set");
   a_mask_rsv: assert property (p_mask_rsv) else $error("correctable mask reserved set");
   a_caps: assert property (p_caps) else $error("ecrc capability bits wrong");
   a_gen_en: assert property (p_gen_en) else $error("ecrc generation enable wrong");
   a_sec_rsv: assert property (p_sec_rsv) else $error("secondary flag reserved set");
   a_bridge: assert property (p_bridge) else $error("internal error flag not set");
   a_ptr: assert property (p_ptr) else $error("secondary control reserved set");
endmodule // aer_checker

bind aer_error_logging_regs aer_checker aer_checker_inst (
   .mclk_in(mclk_in),
   .reset_n_in(reset_n_in),
   .req_in(req_in),
   .internal_error_in(internal_error_in),
   .rdata_out(rdata_out),
   .ecrc_gen_enable_out(ecrc_gen_enable_out)
);
`default_nettype wire

// >>> test/aer_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module aer_far_side (
   // clock
   input wire logic mclk_in,
   // error sources
   output logic [31:0] corr_event_out,
   output logic [31:0] sec_event_out,
   output logic internal_error_out,
   output aer_pkg::primary_error_t primary_error_out,
   output logic release_out,
   // secondary bus pins, idle high
   output logic parity_error_pin_low_out,
   output logic system_error_pin_low_out
);
   initial
   begin
      {corr_event_out, sec_event_out, internal_error_out, release_out} = '0;
      primary_error_out = '0;
      {parity_error_pin_low_out, system_error_pin_low_out} = 2'h3;
   end
   // one-cycle event pulses
   task automatic pulse(input logic [31:0] c, s, input logic i, r);
      @(posedge mclk_in);
      {corr_event_out, sec_event_out, internal_error_out, release_out} <= {c, s, i, r};
      @(posedge mclk_in);
      {corr_event_out, sec_event_out, internal_error_out, release_out} <= '0;
   endtask
   // one-cycle primary error with header
   task automatic prim(input logic [4:0] idx, input logic [127:0] hdr);
      @(posedge mclk_in);
      primary_error_out <= {1'b1, idx, hdr};
      @(posedge mclk_in);
      primary_error_out <= '0;
   endtask
   // pin levels
   task automatic pins(input logic p, s);
      @(posedge mclk_in);
      {parity_error_pin_low_out, system_error_pin_low_out} <= {p, s};
   endtask
endmodule // aer_far_side
`default_nettype wire

// >>> test/aer_error_logging_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module aer_error_logging_regs_bench;
   logic mclk_in;
   logic reset_n_in;
   aer_pkg::reg_req_t req_in;
   logic [31:0] rdata_out;
   logic [31:0] corr_ev;
   logic [31:0] sec_ev;
   logic int_ev;
   aer_pkg::primary_error_t prim_ev;
   logic rel_ev;
   logic par_pin;
   logic sys_pin;
   logic gen_en;
   logic chk_en;
   logic held;
   logic irq;
   int error_cnt;
   int total_checks;
   localparam logic [127:0] HDR = 128'h00112233_44556677_8899aabb_ccddeeff;
   logic [11:0] ofs [13] = '{12'h110, 12'h114, 12'h118, 12'h11c, 12'h120, 12'h124,
      12'h128, 12'h12c, 12'h130, 12'h134, 12'h138, 12'h170, 12'h200};
   logic [31:0] rst_v [13] = '{0, 0, 'ha0, 0, 0, 0, 0, 0, 'h17a8, 'h1340, 0, 0, 0};
   logic [31:0] one_v [13] = '{0, 'h11c1, 'h1e0, 0, 0, 0, 0, 0, 'h3fef, 'h3fef, 0, 0, 0};

   aer_error_logging_regs aer_error_logging_regs_inst (
      .mclk_in(mclk_in), .reset_n_in(reset_n_in), .req_in(req_in), .rdata_out(rdata_out),
      .corr_event_in(corr_ev), .sec_event_in(sec_ev), .internal_error_in(int_ev),
      .primary_error_in(prim_ev), .primary_log_release_in(rel_ev),
      .parity_error_pin_low_in(par_pin), .system_error_pin_low_in(sys_pin),
      .ecrc_gen_enable_out(gen_en), .ecrc_check_enable_out(chk_en),
      .primary_log_held_out(held), .irq_out(irq)
   );
   aer_far_side aer_far_side_inst (
      .mclk_in(mclk_in), .corr_event_out(corr_ev), .sec_event_out(sec_ev),
      .internal_error_out(int_ev), .primary_error_out(prim_ev), .release_out(rel_ev),
      .parity_error_pin_low_out(par_pin), .system_error_pin_low_out(sys_pin)
   );

   initial
   begin
      mclk_in = 1'b0;
      forever #12.5 mclk_in = ~mclk_in;
   end

   task automatic chk(input string n, input logic [31:0] s, e);
      total_checks++;
      if (s !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      req_in <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk_in);
      req_in <= '0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge mclk_in);
      req_in <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge mclk_in);
      req_in <= '0;
      #1;
      chk($sformatf("reg %h", a), rdata_out, e);
   endtask
   task automatic do_reset;
      @(posedge mclk_in);
      reset_n_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      reset_n_in <= 1'b1;
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // watchdog
   initial
   begin
      repeat (5000) @(posedge mclk_in);
      error_cnt++;
      finish_test();
   end

   initial
   begin
      reset_n_in = 1'b0;
      req_in = '0;
      error_cnt = 0;
      total_checks = 0;
      do_reset();
      for (int k = 0; k < 13; k++)
         rd(ofs[k], rst_v[k]);
      $display("test reset values done");
      for (int k = 0; k < 13; k++)
         wr(ofs[k], 32'hffff_ffff);
      for (int k = 0; k < 13; k++)
         rd(ofs[k], one_v[k]);
      chk("ecrc enables", {gen_en, chk_en}, 32'h3);
      $display("test access kinds done");
      do_reset();
      wr(12'h174, 32'h7);
      aer_far_side_inst.pulse(32'hffff_ffff, 32'h0, 1'b0, 1'b0);
      #1;
      chk("irq set", irq, 32'h1);
      rd(12'h110, 32'h11c1);
      rd(12'h170, 32'h1);
      chk("irq clear", irq, 32'h0);
      wr(12'h110, 32'h40);
      rd(12'h110, 32'h1181);
      $display("test correctable done");
      aer_far_side_inst.pulse(32'h0, 32'h0, 1'b1, 1'b0);
      rd(12'h12c, 32'h2000);
      rd(12'h138, 32'hd);
      aer_far_side_inst.pulse(32'h0, 32'hffff_ffff, 1'b0, 1'b0);
      aer_far_side_inst.pins(1'b0, 1'b0);
      repeat (4) @(posedge mclk_in);
      aer_far_side_inst.pins(1'b1, 1'b1);
      rd(12'h12c, 32'h3fef);
      rd(12'h138, 32'hd);
      rd(12'h170, 32'h6);
      wr(12'h12c, 32'hffff_ffff);
      rd(12'h12c, 32'h0);
      aer_far_side_inst.pulse(32'h0, 32'h4, 1'b0, 1'b0);
      rd(12'h138, 32'h2);
      $display("test secondary done");
      aer_far_side_inst.prim(5'h12, HDR);
      rd(12'h118, 32'hb2);
      for (int k = 0; k < 4; k++)
         rd(12'h11c + 12'(4 * k), HDR[127 - 32 * k -: 32]);
      chk("held", held, 32'h1);
      aer_far_side_inst.prim(5'h03, ~HDR);
      rd(12'h11c, HDR[127:96]);
      aer_far_side_inst.pulse(32'h0, 32'h0, 1'b0, 1'b1);
      #1;
      chk("released", held, 32'h0);
      aer_far_side_inst.prim(5'h03, ~HDR);
      rd(12'h118, 32'ha3);
      rd(12'h128, ~HDR[31:0]);
      $display("test primary log done");
      finish_test();
   end
endmodule // aer_error_logging_regs_bench
`default_nettype wire
